//--- rtl/ptc_pkg.sv
`default_nettype none
package ptc_pkg;
  // ==========================================
  // Register map, byte addresses
  localparam logic [31:0] OFS_CTRL = 32'h4400_0700;
  localparam logic [31:0] OFS_INC = 32'h4400_0704;
  localparam logic [31:0] OFS_SEC = 32'h4400_0708;
  localparam logic [31:0] OFS_SUB = 32'h4400_070c;
  localparam logic [31:0] OFS_USEC = 32'h4400_0710;
  localparam logic [31:0] OFS_USUB = 32'h4400_0714;
  localparam logic [31:0] OFS_ADD = 32'h4400_0718;
  localparam logic [31:0] OFS_TSEC = 32'h4400_071c;
  localparam logic [31:0] OFS_TSUB = 32'h4400_0720;
  localparam logic [31:0] OFS_STAT = 32'h4400_0728;
  localparam logic [31:0] OFS_PULSE = 32'h4400_072c;
  localparam logic [31:0] OFS_XSUB = 32'h4400_0730;
  localparam logic [31:0] OFS_XSEC = 32'h4400_0734;
  localparam logic [31:0] OFS_T2SEC = 32'h4400_0780;
  localparam logic [31:0] OFS_T2SUB = 32'h4400_0784;
  // ==========================================
  // Control bit positions and update sign bit
  localparam int CTL_FINE = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_UPD = 3;
  localparam int CTL_ADDL = 5;
  localparam int CTL_DEC = 9;
  localparam int CTL_FCLR = 24;
  localparam int CTL_AUXEN = 25;
  localparam int USUB_SIGN = 31;
  // ==========================================
  // Rollover limits and codes
  localparam logic [31:0] DEC_MAX = 32'h3b9a_c9ff;
  localparam logic [31:0] BIN_MAX = 32'h7fff_ffff;
  localparam logic [31:0] SEC_ALL = 32'hffff_ffff;
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_SINGLE = 4'h1;
  localparam logic [3:0] CMD_TRAIN = 4'h2;
  localparam logic [3:0] CMD_CANCEL = 4'h3;
  localparam logic [3:0] CMD_STOP_AT = 4'h4;
  localparam logic [3:0] CMD_STOP_NOW = 4'h5;
  localparam logic [1:0] MODE_IRQ = 2'h0;
  localparam logic [1:0] MODE_PULSE = 2'h3;
  localparam int AUX_DEPTH = 4;
  localparam logic [2:0] AUX_FULL = 3'h4;
  localparam logic [3:0] TRIG_ID0 = 4'h1;
  // ==========================================
  // Types
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RD = 2'b01,
    BUS_WR = 2'b10
  } ptc_bus_e;
  typedef struct packed {
    logic [31:0] sec;
    logic [30:0] sub;
  } ptc_time_s;
  typedef struct packed {
    ptc_bus_e bus;
    logic [31:0] addr;
    logic [31:0] hrdata;
    logic hready;
    logic [7:0] inc;
    logic dec, fine, init, upd, addl, fclr, auxen;
    ptc_time_s now;
    logic [31:0] upd_sec, upd_sub;
    logic [31:0] addend, addend_act, acc;
    logic [31:0] tgt_sec;
    logic [30:0] tgt_sub;
    logic busy;
    logic [3:0] cmd, act_cmd;
    logic [1:0] mode;
    ptc_time_s act, tgt2;
    logic armed, tvalid, valid2;
    logic err, err2, reached, reached2, ovf, missed, snap;
    logic [2:0] trig;
    ptc_time_s [AUX_DEPTH-1:0] fifo;
    logic [1:0] wp, rp;
    logic [2:0] cnt;
    logic run, tevent;
  } ptc_state_s;
endpackage : ptc_pkg
`default_nettype wire

//--- rtl/ptc_time_counter.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: In coarse mode every clock adds the 8-bit increment to the sub-second count.
// R2: Decimal rollover: one count is 1 ns, wraps to zero after 0x3B9A_C9FF.
// R3: Binary rollover: one count is about 0.465 ns; software scales increment.
// R4: Seconds of system time read back as a 32-bit read-only value.
// R5: Sub-seconds read back as 31 bits, top bit reads zero.
// R6: Seconds update value overwrites seconds on init or offsets on update.
// R7: Update subtracts when the top update bit is one, else adds.
// R8: Software keeps the sub-second update value legal in decimal mode.
// R9: Addend is accumulated each clock for fine frequency correction.
// R10: Reaching the target starts or stops pulse and raises event per mode.
// R11: Busy sets on start-train or cancel code, clears once target is synced.
// R12: Software leaves target registers alone while busy reads one.
// R13: Software keeps target sub-seconds legal in decimal mode.
// R14: Pulse start or stop lands within one increment of the target.
// R15: Snapshot count of four-entry FIFO; FIFO clear resets it to zero.
// R16: Trigger while FIFO full drops the snapshot and sets trigger missed.
// R17: Four-bit trigger identifier; only trigger 0 exists.
// R18: Target error sets when target already elapsed; status read clears it.
// R19: Second target has own reached and read-clear error flags.
// R20: Snapshot flag sets when a snapshot enters the FIFO.
// R21: Target reached sets while time is at or past the target.
// R22: Seconds overflow sets when seconds wrap past all ones.
// R23: Sub-seconds wrap at decimal or binary maximum and bump seconds.
// R24: Init overwrites, update adds or subtracts; both self-clear when done.
// R25: Addend load moves addend into the engine and self-clears.
// R26: Fine-coarse select picks addend-gated or plain per-clock advance.
// R27: Non-error flags hold until their cause goes away or reset.
module ptc_time_counter (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic aux_trigger,
  output logic pulse_active,
  output logic target_event
);
  ptc_pkg::ptc_state_s s_q, s_d;
  ptc_pkg::ptc_time_s head;
  logic [31:0] maxv, rdv, inc_sum, usub, ua, us;
  logic [32:0] acc_sum;
  logic step, wrap, sel, trig_edge, pop, push;
  logic [3:0] trig_id;

  function automatic logic t_ge(ptc_pkg::ptc_time_s a, ptc_pkg::ptc_time_s b);
    t_ge = (a.sec > b.sec) || ((a.sec == b.sec) && (a.sub >= b.sub));
  endfunction : t_ge

  // ==========================================
  // Time engine datapath
  assign maxv = s_q.dec ? ptc_pkg::DEC_MAX : ptc_pkg::BIN_MAX; // R2 R3 R23
  assign acc_sum = {1'b0, s_q.acc} + {1'b0, s_q.addend_act}; // R9
  // Fine mode only steps on accumulator carry
  assign step = !s_q.fine || acc_sum[32]; // R26
  assign inc_sum = {1'b0, s_q.now.sub} + (step ? {24'h0, s_q.inc} : 32'h0); // R1
  assign wrap = inc_sum > maxv; // R23
  assign usub = {1'b0, s_q.upd_sub[30:0]};
  assign ua = {1'b0, s_q.now.sub} + usub;
  assign us = {1'b0, s_q.now.sub} - usub;
  assign sel = hsel && hready && htrans[1] && (s_q.bus == ptc_pkg::BUS_IDLE);
  // Edge taken from second and third stages only
  assign trig_edge = s_q.trig[1] && !s_q.trig[2] && s_q.auxen;
  assign pop = (s_q.bus == ptc_pkg::BUS_RD) && (s_q.addr == ptc_pkg::OFS_XSEC)
               && (s_q.cnt != 3'h0);
  assign push = trig_edge && (s_q.cnt != ptc_pkg::AUX_FULL) && !s_q.fclr;
  assign head = s_q.fifo[s_q.rp];
  assign trig_id = (s_q.cnt != 3'h0) ? ptc_pkg::TRIG_ID0 : 4'h0; // R17

  // ==========================================
  // Read mux
  always_comb
  begin
    unique case (s_q.addr)
      ptc_pkg::OFS_CTRL:
      begin
        rdv = '0;
        rdv[ptc_pkg::CTL_FINE] = s_q.fine;
        rdv[ptc_pkg::CTL_INIT] = s_q.init;
        rdv[ptc_pkg::CTL_UPD] = s_q.upd;
        rdv[ptc_pkg::CTL_ADDL] = s_q.addl;
        rdv[ptc_pkg::CTL_DEC] = s_q.dec;
        rdv[ptc_pkg::CTL_FCLR] = s_q.fclr;
        rdv[ptc_pkg::CTL_AUXEN] = s_q.auxen;
      end
      ptc_pkg::OFS_INC: rdv = {24'h0, s_q.inc};
      ptc_pkg::OFS_SEC: rdv = s_q.now.sec; // R4
      ptc_pkg::OFS_SUB: rdv = {1'b0, s_q.now.sub}; // R5
      ptc_pkg::OFS_USEC: rdv = s_q.upd_sec;
      ptc_pkg::OFS_USUB: rdv = s_q.upd_sub;
      ptc_pkg::OFS_ADD: rdv = s_q.addend;
      ptc_pkg::OFS_TSEC: rdv = s_q.tgt_sec;
      ptc_pkg::OFS_TSUB: rdv = {s_q.busy, s_q.tgt_sub}; // R11
      ptc_pkg::OFS_STAT:
        rdv = {2'h0, 2'h0, s_q.cnt, s_q.missed, 4'h0, trig_id, 10'h0,
               s_q.err2, s_q.reached2, s_q.err, s_q.snap, s_q.reached, s_q.ovf};
      ptc_pkg::OFS_PULSE: rdv = {25'h0, s_q.mode, 1'b0, s_q.cmd};
      ptc_pkg::OFS_XSUB: rdv = {1'b0, head.sub};
      ptc_pkg::OFS_XSEC: rdv = head.sec;
      ptc_pkg::OFS_T2SEC: rdv = s_q.tgt2.sec;
      ptc_pkg::OFS_T2SUB: rdv = {1'b0, s_q.tgt2.sub};
      default: rdv = 32'h0;
    endcase
  end

  // ==========================================
  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.tevent = 1'b0;
    s_d.trig = {s_q.trig[1:0], aux_trigger};
    // Bus address phase; one wait state keeps hrdata registered
    if (sel)
    begin
      s_d.addr = haddr;
      s_d.bus = hwrite ? ptc_pkg::BUS_WR : ptc_pkg::BUS_RD;
      s_d.hready = 1'b0;
    end
    else if (s_q.bus != ptc_pkg::BUS_IDLE)
    begin
      s_d.bus = ptc_pkg::BUS_IDLE;
      s_d.hready = 1'b1;
    end
    if (s_q.bus == ptc_pkg::BUS_RD)
    begin
      s_d.hrdata = rdv;
      if (s_q.addr == ptc_pkg::OFS_STAT)
      begin
        s_d.err = 1'b0; // R18
        s_d.err2 = 1'b0; // R19
      end
    end
    // Free-running advance
    s_d.acc = acc_sum[31:0]; // R9
    if (wrap)
    begin
      s_d.now.sub = 31'(inc_sum - maxv - 32'h1); // R23
      s_d.now.sec = s_q.now.sec + 32'h1; // R23
      if (s_q.now.sec == ptc_pkg::SEC_ALL)
        s_d.ovf = 1'b1; // R22
    end
    else
      s_d.now.sub = inc_sum[30:0]; // R1
    // Coarse corrections take priority over the advance
    if (s_q.init)
    begin
      s_d.now.sec = s_q.upd_sec; // R6
      s_d.now.sub = s_q.upd_sub[30:0]; // R24
      s_d.init = 1'b0; // R24
    end
    else if (s_q.upd)
    begin
      s_d.upd = 1'b0; // R24
      if (s_q.upd_sub[ptc_pkg::USUB_SIGN]) // R7
      begin
        if ({1'b0, s_q.now.sub} >= usub)
        begin
          s_d.now.sub = us[30:0];
          s_d.now.sec = s_q.now.sec - s_q.upd_sec; // R6
        end
        else
        begin
          s_d.now.sub = 31'(us + maxv + 32'h1);
          s_d.now.sec = s_q.now.sec - s_q.upd_sec - 32'h1;
        end
      end
      else if (ua > maxv)
      begin
        s_d.now.sub = 31'(ua - maxv - 32'h1);
        s_d.now.sec = s_q.now.sec + s_q.upd_sec + 32'h1;
      end
      else
      begin
        s_d.now.sub = ua[30:0];
        s_d.now.sec = s_q.now.sec + s_q.upd_sec;
      end
    end
    if (s_q.addl)
    begin
      s_d.addend_act = s_q.addend; // R25
      s_d.addl = 1'b0; // R25
    end
    // Target command transfer into the time domain
    if (s_q.cmd != ptc_pkg::CMD_NONE)
    begin
      s_d.cmd = ptc_pkg::CMD_NONE;
      s_d.busy = 1'b0; // R11
      unique case (s_q.cmd)
        ptc_pkg::CMD_SINGLE, ptc_pkg::CMD_TRAIN, ptc_pkg::CMD_STOP_AT:
        begin
          s_d.act = {s_q.tgt_sec, s_q.tgt_sub};
          s_d.act_cmd = s_q.cmd;
          s_d.armed = 1'b1;
          s_d.tvalid = 1'b1;
          if (t_ge(s_q.now, {s_q.tgt_sec, s_q.tgt_sub}))
            s_d.err = 1'b1; // R18
        end
        ptc_pkg::CMD_STOP_NOW:
        begin
          s_d.run = 1'b0;
          s_d.armed = 1'b0;
        end
        default: s_d.armed = 1'b0;
      endcase
    end
    // Hit checked every clock, so it lags by at most one increment
    if (s_q.armed && t_ge(s_q.now, s_q.act)) // R14
    begin
      s_d.armed = 1'b0;
      if (s_q.mode != ptc_pkg::MODE_PULSE)
        s_d.tevent = 1'b1; // R10
      if (s_q.mode != ptc_pkg::MODE_IRQ)
        s_d.run = (s_q.act_cmd != ptc_pkg::CMD_STOP_AT); // R10
    end
    s_d.reached = s_q.tvalid && t_ge(s_q.now, s_q.act); // R21 R27
    s_d.reached2 = s_q.valid2 && t_ge(s_q.now, s_q.tgt2); // R19 R27
    // Auxiliary snapshot FIFO
    if (push)
    begin
      s_d.fifo[s_q.wp] = s_q.now;
      s_d.wp = s_q.wp + 2'h1;
      s_d.snap = 1'b1; // R20
    end
    if (pop)
      s_d.rp = s_q.rp + 2'h1;
    s_d.cnt = s_q.cnt + {2'h0, push} - {2'h0, pop}; // R15
    if (s_q.fclr)
    begin
      s_d.wp = 2'h0;
      s_d.rp = 2'h0;
      s_d.cnt = 3'h0; // R15
      s_d.fclr = 1'b0;
      s_d.missed = 1'b0; // R27
      s_d.snap = 1'b0; // R27
    end
    // After the clear, so a full-FIFO drop in the clearing cycle is still reported
    if (trig_edge && (s_q.cnt == ptc_pkg::AUX_FULL))
      s_d.missed = 1'b1; // R16
    // Data phase of a write
    if (s_q.bus == ptc_pkg::BUS_WR)
    begin
      unique case (s_q.addr)
        ptc_pkg::OFS_CTRL:
        begin
          s_d.fine = hwdata[ptc_pkg::CTL_FINE]; // R26
          s_d.init = hwdata[ptc_pkg::CTL_INIT];
          s_d.upd = hwdata[ptc_pkg::CTL_UPD];
          s_d.addl = hwdata[ptc_pkg::CTL_ADDL];
          s_d.dec = hwdata[ptc_pkg::CTL_DEC];
          s_d.fclr = hwdata[ptc_pkg::CTL_FCLR];
          s_d.auxen = hwdata[ptc_pkg::CTL_AUXEN];
        end
        ptc_pkg::OFS_INC: s_d.inc = hwdata[7:0];
        ptc_pkg::OFS_USEC: s_d.upd_sec = hwdata;
        ptc_pkg::OFS_USUB: s_d.upd_sub = hwdata;
        ptc_pkg::OFS_ADD: s_d.addend = hwdata;
        ptc_pkg::OFS_TSEC: s_d.tgt_sec = hwdata;
        ptc_pkg::OFS_TSUB: s_d.tgt_sub = hwdata[30:0];
        ptc_pkg::OFS_PULSE:
        begin
          s_d.mode = hwdata[6:5];
          s_d.cmd = hwdata[3:0];
          if ((hwdata[3:0] == ptc_pkg::CMD_TRAIN) || (hwdata[3:0] == ptc_pkg::CMD_CANCEL))
            s_d.busy = 1'b1; // R11
        end
        ptc_pkg::OFS_T2SEC: s_d.tgt2.sec = hwdata;
        ptc_pkg::OFS_T2SUB:
        begin
          s_d.tgt2.sub = hwdata[30:0];
          s_d.valid2 = 1'b1;
          if (t_ge(s_q.now, {s_q.tgt2.sec, hwdata[30:0]}))
            s_d.err2 = 1'b1; // R19
        end
        default:
        begin
        end
      endcase
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
      s_q.hready <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign hreadyout = s_q.hready;
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;
  assign pulse_active = s_q.run;
  assign target_event = s_q.tevent;

  // ==========================================
  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_coarse_step;
    (!s_q.fine && !s_q.init && !s_q.upd && !wrap)
      |=> s_q.now.sub == 31'($past(inc_sum));
  endproperty
  a_coarse_step: assert property (p_coarse_step) else $error("sub-second step wrong"); // R1

  property p_dec_bound;
    (s_q.dec && ({1'b0, s_q.now.sub} <= ptc_pkg::DEC_MAX) && !s_q.init && !s_q.upd)
      |=> ({1'b0, s_q.now.sub} <= ptc_pkg::DEC_MAX);
  endproperty
  a_dec_bound: assert property (p_dec_bound) else $error("decimal bound broken"); // R2

  property p_wrap_sec;
    (wrap && !s_q.init && !s_q.upd) |=> s_q.now.sec == $past(s_q.now.sec) + 32'h1;
  endproperty
  a_wrap_sec: assert property (p_wrap_sec) else $error("wrap missed seconds"); // R23

  property p_ovf;
    (wrap && !s_q.init && !s_q.upd && (s_q.now.sec == ptc_pkg::SEC_ALL)) |=> s_q.ovf;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set"); // R22

  property p_init;
    s_q.init |=> (s_q.now.sec == $past(s_q.upd_sec)) && !s_q.init;
  endproperty
  a_init: assert property (p_init) else $error("init not applied"); // R24

  property p_busy;
    ((s_q.bus == ptc_pkg::BUS_WR) && (s_q.addr == ptc_pkg::OFS_PULSE)
      && (hwdata[3:0] == ptc_pkg::CMD_TRAIN)) |=> s_q.busy ##1 !s_q.busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy sequence wrong"); // R11

  property p_err_clr;
    ((s_q.bus == ptc_pkg::BUS_RD) && (s_q.addr == ptc_pkg::OFS_STAT)
      && (s_q.cmd == ptc_pkg::CMD_NONE)) |=> !s_q.err;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error not cleared"); // R18

  property p_fclr;
    s_q.fclr |=> (s_q.cnt == 3'h0) && !s_q.fclr;
  endproperty
  a_fclr: assert property (p_fclr) else $error("fifo clear failed"); // R15

  property p_missed;
    (trig_edge && (s_q.cnt == ptc_pkg::AUX_FULL) && !s_q.fclr && !pop)
      |=> s_q.missed && (s_q.cnt == ptc_pkg::AUX_FULL);
  endproperty
  a_missed: assert property (p_missed) else $error("missed trigger lost"); // R16

  property p_reached;
    (s_q.tvalid && t_ge(s_q.now, s_q.act)) |=> s_q.reached;
  endproperty
  a_reached: assert property (p_reached) else $error("target reached not set"); // R21

  property p_wait;
    sel |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait: assert property (p_wait) else $error("bus wait state wrong");

  property p_cv_init;
    s_q.init;
  endproperty
  c_init: cover property (p_cv_init);

  property p_cv_hit;
    s_q.armed ##1 target_event;
  endproperty
  c_hit: cover property (p_cv_hit);

  property p_cv_full;
    s_q.cnt == ptc_pkg::AUX_FULL;
  endproperty
  c_full: cover property (p_cv_full);
endmodule : ptc_time_counter
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic hclk, hresetn, hsel, hwrite, aux_trigger, hreadyout, hresp, pulse_active, target_event;
  logic [1:0] htrans, md;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, cb, s0, u0, k, m, v, ds, du;
  int bad_count = 0;
  int cmp_count = 0;
  int ev_count = 0;
  int e0;

  ptc_time_counter dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .aux_trigger(aux_trigger),
    .pulse_active(pulse_active), .target_event(target_event));

  // ==========================================
  // Clock, event counter, watchdog
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk)
  begin
    if (target_event === 1'b1)
      ev_count <= ev_count + 1;
  end

  initial
  begin
    #300000;
    bad_count++;
    tally_and_finish();
  end

  // ==========================================
  // Checking and bus tasks
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // Bounded so a stuck slave shows as a mismatch, not a hang
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20)
      check("bus wait", 32'h0, 32'h1);
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rchk(input string what, input logic [31:0] a, mask, exp);
    xfer(1'b0, a, 32'h0);
    check("okay response", {31'h0, hresp}, 32'h0);
    check(what, rd & mask, exp);
  endtask : rchk

  task automatic ctl(input logic [31:0] x);
    wr(ptc_pkg::OFS_CTRL, cb | x);
  endtask : ctl

  // Increment held at zero so the loaded time stays put
  task automatic set_time(input logic [31:0] s, u);
    wr(ptc_pkg::OFS_INC, 32'h0);
    wr(ptc_pkg::OFS_USEC, s);
    wr(ptc_pkg::OFS_USUB, u);
    ctl(32'h1 << ptc_pkg::CTL_INIT);
  endtask : set_time

  task automatic run_inc(input logic [31:0] inc, input int c);
    wr(ptc_pkg::OFS_INC, inc);
    repeat (c) @(posedge hclk);
    wr(ptc_pkg::OFS_INC, 32'h0);
  endtask : run_inc

  task automatic pcmd(input logic [1:0] mo, input logic [3:0] c);
    wr(ptc_pkg::OFS_PULSE, {25'h0, mo, 1'b0, c});
    repeat (4) @(posedge hclk);
  endtask : pcmd

  function automatic logic [63:0] expect_time(logic [31:0] s, u, inc, int n, logic dec);
    logic [31:0] lim;
    lim = dec ? ptc_pkg::DEC_MAX + 32'h1 : ptc_pkg::BIN_MAX + 32'h1;
    repeat (n)
    begin
      u = u + inc;
      if (u >= lim)
      begin
        u = u - lim;
        s = s + 32'h1;
      end
    end
    return {s, u};
  endfunction : expect_time

  // Exact cycle count of the run is not assumed: a match at any one count from 1 to 79 passes
  task automatic chk_adv(input logic dec);
    logic hit;
    logic [31:0] s;
    hit = 1'b0;
    xfer(1'b0, ptc_pkg::OFS_SEC, 32'h0);
    s = rd;
    xfer(1'b0, ptc_pkg::OFS_SUB, 32'h0);
    for (int n = 1; n < 80; n++)
    begin
      if (expect_time(s0, u0, k, n, dec) === {s, rd})
        hit = 1'b1;
    end
    check("time advance", {31'h0, hit}, 32'h1);
  endtask : chk_adv

  // ==========================================
  // Main sequence
  initial
  begin
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    aux_trigger = 1'b0;
    hresetn = 1'b0;
    cb = 32'h0;
    void'($urandom(9));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("reset seconds", ptc_pkg::OFS_SEC, '1, 32'h0);
    rchk("reset subseconds", ptc_pkg::OFS_SUB, '1, 32'h0);
    rchk("reset status", ptc_pkg::OFS_STAT, '1, 32'h0);
    wr(ptc_pkg::OFS_SEC, 32'h1234_5678);
    rchk("read-only seconds", ptc_pkg::OFS_SEC, '1, 32'h0);
    wr(32'h4400_07fc, 32'hffff_ffff);
    rchk("unmapped", 32'h4400_07fc, '1, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      v = $urandom;
      wr(ptc_pkg::OFS_USEC, v);
      rchk("seconds update", ptc_pkg::OFS_USEC, '1, v);
      wr(ptc_pkg::OFS_ADD, v);
      rchk("addend", ptc_pkg::OFS_ADD, '1, v);
      wr(ptc_pkg::OFS_TSEC, v);
      rchk("target seconds", ptc_pkg::OFS_TSEC, '1, v);
    end
    wr(ptc_pkg::OFS_TSUB, 32'hffff_ffff);
    rchk("target sub, idle busy", ptc_pkg::OFS_TSUB, '1, 32'h7fff_ffff);
    // Rollover in both modes; last pass wraps the seconds
    for (int i = 0; i < 4; i++)
    begin
      cb[ptc_pkg::CTL_DEC] = i[0];
      m = i[0] ? ptc_pkg::DEC_MAX : ptc_pkg::BIN_MAX;
      k = $urandom_range(255, 1);
      s0 = (i == 3) ? ptc_pkg::SEC_ALL : $urandom;
      u0 = m + 32'h1 - k * $urandom_range(6, 2);
      set_time(s0, u0);
      rchk("init seconds", ptc_pkg::OFS_SEC, '1, s0);
      rchk("init subseconds", ptc_pkg::OFS_SUB, '1, u0);
      rchk("control self clear", ptc_pkg::OFS_CTRL, 32'h2c, 32'h0);
      wr(ptc_pkg::OFS_INC, k);
      rchk("increment", ptc_pkg::OFS_INC, 32'hff, k);
      repeat (10) @(posedge hclk);
      wr(ptc_pkg::OFS_INC, 32'h0);
      chk_adv(i[0]);
      rchk("overflow", ptc_pkg::OFS_STAT, 32'h1, {31'h0, i == 3});
    end
    // Add then subtract an offset
    for (int i = 0; i < 2; i++)
    begin
      s0 = $urandom_range(32'h4000_0000, 32'h0010_0000);
      ds = $urandom_range(32'h000f_ffff, 0);
      du = $urandom_range(32'h07ff_ffff, 0);
      set_time(s0, 32'h1000_0000);
      wr(ptc_pkg::OFS_USEC, ds);
      wr(ptc_pkg::OFS_USUB, {i[0], du[30:0]});
      ctl(32'h1 << ptc_pkg::CTL_UPD);
      rchk("updated seconds", ptc_pkg::OFS_SEC, '1, i ? s0 - ds : s0 + ds);
      rchk("updated sub", ptc_pkg::OFS_SUB, '1, i ? 32'h1000_0000 - du : 32'h1000_0000 + du);
    end
    // Fine correction gated by the addend accumulator carry
    cb[ptc_pkg::CTL_FINE] = 1'b1;
    set_time(32'h1, 32'h0);
    wr(ptc_pkg::OFS_ADD, 32'h0);
    ctl(32'h1 << ptc_pkg::CTL_ADDL);
    run_inc(32'h10, 8);
    rchk("fine, zero addend", ptc_pkg::OFS_SUB, '1, 32'h0);
    wr(ptc_pkg::OFS_ADD, 32'hffff_ffff);
    ctl(32'h1 << ptc_pkg::CTL_ADDL);
    run_inc(32'h10, 8);
    xfer(1'b0, ptc_pkg::OFS_SUB, 32'h0);
    check("fine advance", {31'h0, rd != 32'h0 && rd[3:0] == 4'h0}, 32'h1);
    cb[ptc_pkg::CTL_FINE] = 1'b0;
    // Elapsed target in modes 0, 2 and 3
    set_time(32'd100, 32'h100);
    wr(ptc_pkg::OFS_TSEC, 32'd99);
    wr(ptc_pkg::OFS_TSUB, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      md = (i == 0) ? 2'h0 : (i == 1) ? 2'h2 : 2'h3;
      e0 = ev_count;
      pcmd(md, ptc_pkg::CMD_SINGLE);
      check("event count", 32'(ev_count - e0), {31'h0, md != 2'h3});
      check("pulse start", 32'(pulse_active), {31'h0, md[1]});
      rchk("target flags", ptc_pkg::OFS_STAT, 32'ha, 32'ha);
      rchk("error read clear", ptc_pkg::OFS_STAT, 32'ha, 32'h2);
      pcmd(2'h2, ptc_pkg::CMD_STOP_NOW);
      check("pulse stop now", 32'(pulse_active), 32'h0);
    end
    // Future start, stop at time, cancel
    wr(ptc_pkg::OFS_TSEC, 32'd100);
    wr(ptc_pkg::OFS_TSUB, 32'h400);
    pcmd(2'h3, ptc_pkg::CMD_TRAIN);
    rchk("not yet reached", ptc_pkg::OFS_STAT, 32'ha, 32'h0);
    check("no early start", 32'(pulse_active), 32'h0);
    run_inc(32'h40, 20);
    check("train start", 32'(pulse_active), 32'h1);
    rchk("reached", ptc_pkg::OFS_STAT, 32'ha, 32'h2);
    wr(ptc_pkg::OFS_TSUB, 32'h2000);
    pcmd(2'h3, ptc_pkg::CMD_STOP_AT);
    check("no early stop", 32'(pulse_active), 32'h1);
    run_inc(32'hff, 40);
    check("stop at time", 32'(pulse_active), 32'h0);
    wr(ptc_pkg::OFS_TSUB, 32'h3000_0000);
    pcmd(2'h3, ptc_pkg::CMD_SINGLE);
    pcmd(2'h3, ptc_pkg::CMD_CANCEL);
    wr(ptc_pkg::OFS_USEC, 32'h0);
    wr(ptc_pkg::OFS_USUB, 32'h3000_0000);
    ctl(32'h1 << ptc_pkg::CTL_UPD);
    repeat (4) @(posedge hclk);
    check("cancelled start", 32'(pulse_active), 32'h0);
    // Second target
    wr(ptc_pkg::OFS_T2SEC, 32'd99);
    wr(ptc_pkg::OFS_T2SUB, 32'h0);
    repeat (4) @(posedge hclk);
    rchk("second target", ptc_pkg::OFS_STAT, 32'h30, 32'h30);
    rchk("second error clear", ptc_pkg::OFS_STAT, 32'h30, 32'h10);
    // Snapshot FIFO: five triggers into four places
    cb[ptc_pkg::CTL_AUXEN] = 1'b1;
    set_time(32'd7, 32'h55);
    repeat (5)
    begin
      aux_trigger <= 1'b1;
      repeat (5) @(posedge hclk);
      aux_trigger <= 1'b0;
      repeat (5) @(posedge hclk);
    end
    rchk("fifo full", ptc_pkg::OFS_STAT, 32'h3f0f_0004, 32'h0901_0004);
    rchk("snapshot sub", ptc_pkg::OFS_XSUB, '1, 32'h55);
    rchk("snapshot sec", ptc_pkg::OFS_XSEC, '1, 32'd7);
    rchk("after pop", ptc_pkg::OFS_STAT, 32'h3e00_0000, 32'h0600_0000);
    ctl(32'h1 << ptc_pkg::CTL_FCLR);
    ctl(32'h0);
    rchk("fifo cleared", ptc_pkg::OFS_STAT, 32'h3e00_0000, 32'h0);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
